// file: logic/aic_consts.svh
// Constants of the amplifier control link: address, field positions, resets, host map and timing.
// Assumes inclusion by bare name from both ends; definitions only.
`ifndef AIC_CONSTS_SVH
`define AIC_CONSTS_SVH
// Fixed upper five bits of the seven-bit slave address.
`define AIC_ADDR_HI 5'h1a
// Field positions in the first control byte.
`define AIC_C1_DIAG 6
`define AIC_C1_OFFS 5
`define AIC_C1_GAIN 4
`define AIC_C1_UNMUTE 2
`define AIC_C1_CLIP 0
// Field positions in the second control byte.
`define AIC_C2_RUN 4
`define AIC_C2_LINE 3
`define AIC_C2_HEFF 1
// Field positions in the channel one status byte.
`define AIC_S1_THERM 7
`define AIC_S1_DONE 6
`define AIC_S1_PERM 4
`define AIC_S1_SHORT 3
`define AIC_S1_OPEN 2
`define AIC_S1_SUPPLY 1
`define AIC_S1_GND 0
// Control bytes come out of reset muted, in standby, diagnostics off.
`define AIC_CTL_RESET 8'h00
// Host register offsets on its APB port.
`define AIC_REG_CMD 8'h00
`define AIC_REG_TX 8'h04
`define AIC_REG_RX 8'h08
`define AIC_REG_STAT 8'h0c
// Command fields.
`define AIC_CMD_GO 0
`define AIC_CMD_READ 1
`define AIC_CMD_SEL_LO 2
// Link clock period the host makes, and the system clock period, in ns.
`define AIC_SCL_NS 160
`define AIC_CLK_NS 10
`define AIC_QTR_CYC ((`AIC_SCL_NS / `AIC_CLK_NS) / 4)
`endif

// file: logic/aic_pkg.sv
// Types shared by both ends of the amplifier control link.
// Assumes the constants header sits beside it.
package aic_pkg;
  // Device end receiver and transmitter states.
  typedef enum logic [5:0] {
    DEV_IDLE = 6'h01,
    DEV_ADDR = 6'h02,
    DEV_ACK = 6'h04,
    DEV_WRX = 6'h08,
    DEV_RDX = 6'h10,
    DEV_RACK = 6'h20
  } aic_dev_state_t;
  // Host end sequencer states.
  typedef enum logic [3:0] {
    HST_IDLE = 4'h1,
    HST_STRT = 4'h2,
    HST_XFER = 4'h4,
    HST_STOP = 4'h8
  } aic_host_state_t;
endpackage : aic_pkg

// file: logic/aic_i2c_if.sv
// Two-wire link between the host end and the amplifier end.
// Assumes pull-ups: a line is low only while some end enables its driver low.
`timescale 1ns/1ps
interface aic_i2c_if;
  logic sclHostOut;
  logic sclHostOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic scl;
  logic sda;
  // Wired-AND of the open-drain drivers.
  assign scl = ~(sclHostOe & ~sclHostOut);
  assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));
  modport host (output sclHostOut, output sclHostOe, output sdaHostOut, output sdaHostOe, input scl, input sda);
  modport dev (output sdaDevOut, output sdaDevOe, input scl, input sda);
endinterface : aic_i2c_if

// file: logic/aic_device.sv
// Amplifier end of the control link: two-wire slave, control bytes and channel one status.
// Assumes the link lines and board pins are asynchronous to clk; fault inputs are on clk.
//
// Functional notes
// - Data changes only while clock low.
// - Master frames transfers with start and stop.
// - Eight bits, MSB first, then acknowledge.
// - Receiver pulls data low during acknowledge.
// - Address bit zero selects write or read.
// - Write carries control byte one, then two.
// - Read returns channel one status first.
// - Control one bit 6 enables diagnostics.
// - Control one bit 5 enables offset detection.
// - Control one bit 4 picks 12dB gain.
// - Control one bit 2 clear means mute.
// - Control one bit 0 picks 10% clip.
// - Control two bit 4 leaves standby.
// - Control two bit 3 picks line-driver thresholds.
// - Control two bit 1 picks high efficiency.
// - Standby pin low always forces amplifier off.
// - Status bit 7 is thermal warning.
// - Status bit 6 means diagnostic cycle finished.
// - Status bit 4 marks permanent diagnostic results.
// - Status bit 3 flags shorted load.
// - Status bit 2 flags open load or offset.
// - Status bits 1,0 flag supply, ground shorts.
// - Status read restarts the next diagnostic cycle.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "aic_consts.svh"
module aic_device
  import aic_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Link.
  aic_i2c_if.dev link,
  // Board pins.
  input wire logic [1:0] addrStrap,
  input wire logic busEnablePin,
  input wire logic standbyPin,
  // Fault and diagnostic inputs.
  input wire logic thermalWarning,
  input wire logic diagTerminated,
  input wire logic permanentDiag,
  input wire logic shortLoad,
  input wire logic openOrOffset,
  input wire logic shortSupply,
  input wire logic shortGround,
  input wire logic [7:0] channel_two_status,
  // Control outputs.
  output logic diagEnable,
  output logic offsetDetectEnable,
  output logic gainLow,
  output logic unmute,
  output logic clip_detect_threshold,
  output logic amplifierOn,
  output logic lineDriverMode,
  output logic high_efficiency_operation,
  output logic diagRestart
);

  // Two-flop synchronisers for everything that comes from outside clk.
  logic sclM_q, sclS_q, sclP_q, sdaM_q, sdaS_q, sdaP_q;
  logic [1:0] strapM_q, strapS_q;
  logic enM_q, enS_q, stbM_q, stbS_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {sclM_q, sclS_q, sclP_q, sdaM_q, sdaS_q, sdaP_q} <= 6'h3f;
      {strapM_q, strapS_q} <= 4'h0;
      {enM_q, enS_q, stbM_q, stbS_q} <= 4'h0;
    end else begin
      {sclP_q, sclS_q, sclM_q} <= {sclS_q, sclM_q, link.scl};
      {sdaP_q, sdaS_q, sdaM_q} <= {sdaS_q, sdaM_q, link.sda};
      {strapS_q, strapM_q} <= {strapM_q, addrStrap};
      {enS_q, enM_q} <= {enM_q, busEnablePin};
      {stbS_q, stbM_q} <= {stbM_q, standbyPin};
    end
  end

  // Line events, seen only on the second and third flops.
  wire sclRise = sclS_q & ~sclP_q;
  wire sclFall = ~sclS_q & sclP_q;
  wire startSeen = sclS_q & sclP_q & sdaP_q & ~sdaS_q;
  wire stopSeen = sclS_q & sclP_q & ~sdaP_q & sdaS_q;

  aic_dev_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [1:0] byteIdx_q;
  logic readDir_q, sdaOe_q, acked_q, readDone_q, restart_q;
  logic [7:0] ctl1_q, ctl2_q;
  logic ampOn_q;

  // Status bytes; bit 5 of the first has no meaning and reads zero.
  wire [7:0] status1 = {thermalWarning, diagTerminated, 1'b0, permanentDiag,
                        shortLoad, openOrOffset, shortSupply, shortGround};
  wire addrHit = (shift_q[7:3] == `AIC_ADDR_HI) && (shift_q[2:1] == strapS_q);
  wire byteDone = (bitCnt_q == 4'h8);
  wire [7:0] shiftIn = {shift_q[6:0], sdaS_q};

  // Protocol engine. Start and stop win over any bit in flight, so a truncated frame never
  // leaves the data line held low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= DEV_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      byteIdx_q <= 2'h0;
      readDir_q <= 1'b0;
      sdaOe_q <= 1'b0;
      acked_q <= 1'b0;
      readDone_q <= 1'b0;
      restart_q <= 1'b0;
      ctl1_q <= `AIC_CTL_RESET;
      ctl2_q <= `AIC_CTL_RESET;
    end else begin
      restart_q <= 1'b0;
      if (stopSeen) begin
        state_q <= DEV_IDLE;
        sdaOe_q <= 1'b0;
        restart_q <= readDone_q;
        readDone_q <= 1'b0;
      end else if (startSeen) begin
        state_q <= DEV_ADDR;
        bitCnt_q <= 4'h0;
        byteIdx_q <= 2'h0;
        sdaOe_q <= 1'b0;
      end else begin
        unique case (state_q)
          DEV_IDLE: begin
          end
          DEV_ADDR: begin
            if (sclRise) begin
              shift_q <= shiftIn;
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && byteDone) begin
              // Drive only after the clock is low again.
              state_q <= addrHit ? DEV_ACK : DEV_IDLE;
              sdaOe_q <= addrHit;
              readDir_q <= shift_q[0];
            end
          end
          DEV_WRX: begin
            if (sclRise) begin
              shift_q <= shiftIn;
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && byteDone) begin
              if (byteIdx_q == 2'h0) begin
                ctl1_q <= shift_q;
              end
              if (byteIdx_q == 2'h1) begin
                ctl2_q <= shift_q;
              end
              // A third byte is not acknowledged.
              state_q <= (byteIdx_q < 2'h2) ? DEV_ACK : DEV_IDLE;
              sdaOe_q <= (byteIdx_q < 2'h2);
              byteIdx_q <= byteIdx_q + 2'h1;
            end
          end
          DEV_ACK: begin
            if (sclFall) begin
              bitCnt_q <= 4'h0;
              if (readDir_q) begin
                state_q <= DEV_RDX;
                shift_q <= status1;
                sdaOe_q <= ~status1[7];
              end else begin
                state_q <= DEV_WRX;
                sdaOe_q <= 1'b0;
              end
            end
          end
          DEV_RDX: begin
            if (sclRise) begin
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall) begin
              if (byteDone) begin
                state_q <= DEV_RACK;
                sdaOe_q <= 1'b0;
                readDone_q <= 1'b1;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sdaOe_q <= ~shift_q[6];
              end
            end
          end
          DEV_RACK: begin
            if (sclRise) begin
              acked_q <= ~sdaS_q;
            end else if (sclFall) begin
              bitCnt_q <= 4'h0;
              if (acked_q && byteIdx_q == 2'h0) begin
                state_q <= DEV_RDX;
                byteIdx_q <= 2'h1;
                shift_q <= channel_two_status;
                sdaOe_q <= ~channel_two_status[7];
              end else begin
                state_q <= DEV_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // Power state: the pin can always pull the amplifier down; with the bus live, turning
  // on also needs the bus command.
  wire ampOnNext = stbS_q & (~enS_q | ctl2_q[`AIC_C2_RUN]);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ampOn_q <= 1'b0;
    end else begin
      ampOn_q <= ampOnNext;
    end
  end

  // Control fields straight from the stored bytes.
  assign diagEnable = ctl1_q[`AIC_C1_DIAG];
  assign offsetDetectEnable = ctl1_q[`AIC_C1_OFFS];
  assign gainLow = ctl1_q[`AIC_C1_GAIN];
  assign unmute = ctl1_q[`AIC_C1_UNMUTE];
  assign clip_detect_threshold = ctl1_q[`AIC_C1_CLIP];
  assign lineDriverMode = ctl2_q[`AIC_C2_LINE];
  assign high_efficiency_operation = ctl2_q[`AIC_C2_HEFF];
  assign amplifierOn = ampOn_q;
  assign diagRestart = restart_q;
  assign link.sdaDevOut = 1'b0;
  assign link.sdaDevOe = sdaOe_q;
endmodule : aic_device

// file: logic/aic_host.sv
// Host end of the control link: an APB slave whose commands run one write or read frame.
// Assumes software polls the busy bit; SCL is made here by dividing clk.
`timescale 1ns/1ps
`include "aic_consts.svh"
module aic_host
  import aic_pkg::*;
#(
  parameter int QTR = `AIC_QTR_CYC
)(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link.
  aic_i2c_if.host link
);

  // Data line sampled through two flops.
  logic sdaM_q, sdaS_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {sdaM_q, sdaS_q} <= 2'h3;
    end else begin
      {sdaS_q, sdaM_q} <= {sdaM_q, link.sda};
    end
  end

  aic_host_state_t state_q;
  logic [7:0] divCnt_q;
  logic [1:0] phase_q;
  logic [3:0] bitCnt_q;
  logic [1:0] byteCnt_q, sel_q;
  logic rd_q, sclOe_q, sdaOe_q, ackLow_q, nack_q;
  logic [7:0] rxSh_q;
  logic [15:0] tx_q, rx_q;

  // APB decode; zero wait states, unmapped offsets answer with an error.
  wire access = psel & penable;
  wire hitCmd = (paddr == `AIC_REG_CMD);
  wire hitTx = (paddr == `AIC_REG_TX);
  wire hitRx = (paddr == `AIC_REG_RX);
  wire hitStat = (paddr == `AIC_REG_STAT);
  wire busy = (state_q != HST_IDLE);
  wire launch = access & pwrite & hitCmd & pwdata[`AIC_CMD_GO] & ~busy;
  assign pready = 1'b1;
  assign pslverr = access & ~(hitCmd | hitTx | hitRx | hitStat);
  assign prdata = hitTx ? {16'h0000, tx_q} :
                  hitRx ? {16'h0000, rx_q} :
                  hitStat ? {27'h0000000, sel_q, rd_q, nack_q, busy} :
                  32'h00000000;

  // Bit source for the current slot; the host acknowledges all read bytes but the last.
  wire [7:0] txByte = (byteCnt_q == 2'h0) ? {`AIC_ADDR_HI, sel_q, rd_q} :
                      (byteCnt_q == 2'h1) ? tx_q[7:0] : tx_q[15:8];
  wire [7:0] txSh = txByte << bitCnt_q[2:0];
  wire inData = (bitCnt_q < 4'h8);
  wire hostDrives = inData ? (~rd_q | (byteCnt_q == 2'h0)) : (rd_q & (byteCnt_q != 2'h0));
  wire bitVal = inData ? txSh[7] : (byteCnt_q == 2'h2);
  wire tick = (divCnt_q == 8'(QTR - 1));

  // Quarter-period divider, idle between frames.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_q <= 8'h00;
      phase_q <= 2'h0;
    end else if (!busy) begin
      divCnt_q <= 8'h00;
      phase_q <= 2'h0;
    end else begin
      divCnt_q <= tick ? 8'h00 : divCnt_q + 8'h01;
      phase_q <= tick ? phase_q + 2'h1 : phase_q;
    end
  end

  // Frame sequencer: phase 0 clock low and data set, 1 clock high, 2 sample, 3 clock low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= HST_IDLE;
      bitCnt_q <= 4'h0;
      byteCnt_q <= 2'h0;
      sel_q <= 2'h0;
      rd_q <= 1'b0;
      sclOe_q <= 1'b0;
      sdaOe_q <= 1'b0;
      ackLow_q <= 1'b0;
      nack_q <= 1'b0;
      rxSh_q <= 8'h00;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
    end else begin
      if (access && pwrite && hitTx) begin
        tx_q <= pwdata[15:0];
      end
      if (launch) begin
        state_q <= HST_STRT;
        rd_q <= pwdata[`AIC_CMD_READ];
        sel_q <= pwdata[`AIC_CMD_SEL_LO +: 2];
        nack_q <= 1'b0;
        bitCnt_q <= 4'h0;
        byteCnt_q <= 2'h0;
      end else if (tick) begin
        unique case (state_q)
          HST_IDLE: begin
          end
          HST_STRT: begin
            // Data falls while clock is high, then clock falls.
            if (phase_q == 2'h1) begin
              sdaOe_q <= 1'b1;
            end
            // Clock falls with the move to the bit slots, so every low phase lasts two quarters.
            if (phase_q == 2'h3) begin
              sclOe_q <= 1'b1;
              state_q <= HST_XFER;
            end
          end
          HST_XFER: begin
            unique case (phase_q)
              2'h0: sdaOe_q <= hostDrives & ~bitVal;
              2'h1: sclOe_q <= 1'b0;
              2'h2: begin
                if (inData) begin
                  rxSh_q <= {rxSh_q[6:0], sdaS_q};
                end else begin
                  ackLow_q <= ~sdaS_q;
                end
              end
              2'h3: begin
                sclOe_q <= 1'b1;
                if (inData) begin
                  bitCnt_q <= bitCnt_q + 4'h1;
                end else begin
                  bitCnt_q <= 4'h0;
                  if (rd_q && byteCnt_q == 2'h1) begin
                    rx_q[7:0] <= rxSh_q;
                  end
                  if (rd_q && byteCnt_q == 2'h2) begin
                    rx_q[15:8] <= rxSh_q;
                  end
                  if (!hostDrives && !ackLow_q) begin
                    nack_q <= 1'b1;
                    state_q <= HST_STOP;
                  end else if (byteCnt_q == 2'h2) begin
                    state_q <= HST_STOP;
                  end else begin
                    byteCnt_q <= byteCnt_q + 2'h1;
                  end
                end
              end
            endcase
          end
          HST_STOP: begin
            // Data rises while clock is high.
            unique case (phase_q)
              2'h0: sdaOe_q <= 1'b1;
              2'h1: sclOe_q <= 1'b0;
              2'h2: sdaOe_q <= 1'b0;
              2'h3: state_q <= HST_IDLE;
            endcase
          end
        endcase
      end
    end
  end

  assign link.sclHostOut = 1'b0;
  assign link.sclHostOe = sclOe_q;
  assign link.sdaHostOut = 1'b0;
  assign link.sdaHostOe = sdaOe_q;
endmodule : aic_host

// file: verification/aic_link_properties.sv
// Checker for the two-wire control link: timing and ownership of the lines.
// Assumes it sits beside the link interface, on the system clock and the bench reset.
`timescale 1ns/1ps
module aic_link_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Resolved lines and driver enables.
  input wire logic scl,
  input wire logic sda,
  input wire logic sclHostOe,
  input wire logic sdaHostOe,
  input wire logic sdaDevOe
);
  logic sclQ_q, sdaQ_q, rdFrame_q;
  logic [3:0] bitCnt_q;
  logic [2:0] byteCnt_q;
  // Line events seen against the previous sample.
  wire sclRise = scl & ~sclQ_q;
  wire sclHeld = scl & sclQ_q;
  wire startSeen = sclHeld & sdaQ_q & ~sda;
  wire stopSeen = sclHeld & ~sdaQ_q & sda;
  wire ackSlot = sclRise & (bitCnt_q == 4'h9 - 4'h1);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Bit position in the byte; the ninth clock is the acknowledge, so the bit count wraps after eight and the byte count holds at seven.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclQ_q <= 1'b1;
      sdaQ_q <= 1'b1;
      bitCnt_q <= 4'h0;
      byteCnt_q <= 3'h0;
      rdFrame_q <= 1'b0;
    end else begin
      sclQ_q <= scl;
      sdaQ_q <= sda;
      if (startSeen) begin
        bitCnt_q <= 4'h0;
        byteCnt_q <= 3'h0;
        rdFrame_q <= 1'b0;
      end else if (sclRise) begin
        bitCnt_q <= ackSlot ? 4'h0 : bitCnt_q + 4'h1;
        byteCnt_q <= (ackSlot && byteCnt_q != 3'h7) ? byteCnt_q + 3'h1 : byteCnt_q;
        rdFrame_q <= (bitCnt_q == 4'h7 && byteCnt_q == 3'h0) ? sda : rdFrame_q;
      end
    end
  end
  // A low clock phase lasts two quarters, so the device always has its setup time.
  sequence sLowPhase;
    sclHostOe [*7] ##[1:5] !sclHostOe;
  endsequence
  a_dev_hold_high: assert property (sclHeld |-> $stable(sdaDevOe))
    else $error("device data moved with clock high");
  a_start_by_host: assert property (startSeen |-> $rose(sdaHostOe))
    else $error("start not made by host");
  a_stop_by_host: assert property (stopSeen |-> $fell(sdaHostOe))
    else $error("stop not made by host");
  a_host_hold_high: assert property (sclHeld && !startSeen && !stopSeen |-> $stable(sdaHostOe))
    else $error("host data moved with clock high");
  // The stop's own clock rise opens a slot of a byte that never comes, so the count reads one.
  a_stop_on_boundary: assert property (stopSeen |-> bitCnt_q == 4'h1)
    else $error("stop inside a byte");
  a_host_frees_ack: assert property (ackSlot && (byteCnt_q == 3'h0 || !rdFrame_q) |-> !sdaHostOe)
    else $error("host drives data in device acknowledge");
  a_dev_frees_ack: assert property (ackSlot && byteCnt_q != 3'h0 && rdFrame_q |-> !sdaDevOe)
    else $error("device drives data in host acknowledge");
  a_dev_quiet_write: assert property (sdaDevOe && !rdFrame_q |-> bitCnt_q inside {4'h0, 4'h8})
    else $error("device drives data bits in a write");
  a_scl_low_hold: assert property ($rose(sclHostOe) |-> sLowPhase)
    else $error("clock low phase of wrong length");
endmodule : aic_link_properties

// file: verification/amp_i2c_control_diag_tb_top.sv
// Bench for the control link: APB host end and amplifier end joined by the two-wire link.
// Assumes the host answers APB promptly; the bench waits on pready and its cycle timeout ends a hang.
`timescale 1ns/1ps
`include "aic_consts.svh"
module amp_i2c_control_diag_tb_top;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, stIn, chTwo;
  logic [31:0] pwdata, prdata;
  logic [1:0] addrStrap;
  logic busEnablePin, standbyPin, diagEnable, offsetDetectEnable, gainLow, unmute;
  logic clipSel, amplifierOn, lineDriverMode, heMode, diagRestart;
  int fails = 0;
  int testsRun = 0;
  int restarts = 0;
  int cycles = 0;
  aic_i2c_if linkIf();
  aic_host aic_host_i (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .link(linkIf));
  aic_device aic_device_i (.clk, .rstn, .link(linkIf), .addrStrap, .busEnablePin, .standbyPin,
    .thermalWarning(stIn[7]), .diagTerminated(stIn[6]), .permanentDiag(stIn[4]), .shortLoad(stIn[3]),
    .openOrOffset(stIn[2]), .shortSupply(stIn[1]), .shortGround(stIn[0]), .channel_two_status(chTwo),
    .diagEnable, .offsetDetectEnable, .gainLow, .unmute, .clip_detect_threshold(clipSel), .amplifierOn,
    .lineDriverMode, .high_efficiency_operation(heMode), .diagRestart);
  aic_link_properties aic_link_properties_i (.clk, .rstn, .scl(linkIf.scl), .sda(linkIf.sda),
    .sclHostOe(linkIf.sclHostOe), .sdaHostOe(linkIf.sdaHostOe), .sdaDevOe(linkIf.sdaDevOe));
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic chkBit(input string what, input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chkBit
  task automatic chkByte(input string what, input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chkByte
  // One APB transfer; the request is held until pready is seen high in the access phase.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    chkBit("pslverr", pslverr, a > `AIC_REG_STAT);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Start one frame and poll busy; the device sees the stop a few clocks late, hence the tail wait.
  task automatic frame(input logic rd, input logic [1:0] sel, output logic nack);
    logic [31:0] r;
    apb(1'b1, `AIC_REG_CMD, {28'h0, sel, rd, 1'b1}, r);
    r = 32'h1;
    // A frame that never ends is caught by the cycle timeout, which counts it as a mismatch.
    while (r[0] !== 1'b0) begin
      apb(1'b0, `AIC_REG_STAT, 32'h0, r);
    end
    nack = r[1];
    repeat (8) @(posedge clk);
  endtask : frame
  task automatic wrCtl(input logic [7:0] c1, input logic [7:0] c2, input logic [1:0] sel, output logic nack);
    logic [31:0] r;
    apb(1'b1, `AIC_REG_TX, {16'h0, c2, c1}, r);
    frame(1'b0, sel, nack);
  endtask : wrCtl
  task automatic chkCtl(input logic [7:0] c1, input logic [7:0] c2);
    chkBit("diag", diagEnable, c1[`AIC_C1_DIAG]);
    chkBit("offset", offsetDetectEnable, c1[`AIC_C1_OFFS]);
    chkBit("gain", gainLow, c1[`AIC_C1_GAIN]);
    chkBit("unmute", unmute, c1[`AIC_C1_UNMUTE]);
    chkBit("clip", clipSel, c1[`AIC_C1_CLIP]);
    chkBit("line", lineDriverMode, c2[`AIC_C2_LINE]);
    chkBit("heff", heMode, c2[`AIC_C2_HEFF]);
  endtask : chkCtl
  task automatic tReset();
    logic [31:0] r;
    chkCtl(8'h00, 8'h00);
    chkBit("amp", amplifierOn, 1'b0);
    apb(1'b0, 8'h10, 32'h0, r);
  endtask : tReset
  // Every mapped bit set, then every mapped bit cleared, with the unused bits doing the opposite except control two bits 6 and 5, which stay clear.
  task automatic tFields();
    logic [15:0] pat [2];
    logic nack;
    pat = '{16'h1a75, 16'h858a};
    for (int i = 0; i < 2; i++) begin
      wrCtl(pat[i][7:0], pat[i][15:8], addrStrap, nack);
      chkBit("nack", nack, 1'b0);
      chkCtl(pat[i][7:0], pat[i][15:8]);
      chkBit("amp", amplifierOn, pat[i][8 + `AIC_C2_RUN]);
    end
  endtask : tFields
  task automatic tStandby();
    logic nack;
    wrCtl(8'h00, 8'h10, addrStrap, nack);
    standbyPin <= 1'b0;
    repeat (8) @(posedge clk);
    chkBit("amp pin low", amplifierOn, 1'b0);
    standbyPin <= 1'b1;
    repeat (8) @(posedge clk);
    chkBit("amp pin high", amplifierOn, 1'b1);
    wrCtl(8'h00, 8'h00, addrStrap, nack);
    chkBit("amp cmd off", amplifierOn, 1'b0);
    busEnablePin <= 1'b0;
    repeat (8) @(posedge clk);
    chkBit("amp bus off", amplifierOn, 1'b1);
    busEnablePin <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : tStandby
  // Each fault input is seen high once and low once; bit 5 must read zero.
  task automatic tStatus();
    logic [7:0] sts [2];
    logic [31:0] r;
    logic nack;
    sts = '{8'hf5, 8'h0a};
    chkByte("restarts", 8'(restarts), 8'h00);
    for (int i = 0; i < 2; i++) begin
      stIn <= sts[i];
      chTwo <= ~sts[i];
      frame(1'b1, addrStrap, nack);
      chkBit("read nack", nack, 1'b0);
      apb(1'b0, `AIC_REG_RX, 32'h0, r);
      chkByte("status one", r[7:0], sts[i] & 8'hdf);
      chkByte("status two", r[15:8], ~sts[i]);
      chkByte("restarts", 8'(restarts), 8'(i + 1));
    end
  endtask : tStatus
  // A wrong address is ignored whole; the strapped one takes the same bytes.
  task automatic tAddress();
    logic nack;
    logic u;
    u = 1'b0;
    for (int i = 0; i < 4; i++) begin
      addrStrap <= 2'(i);
      wrCtl({5'h0, ~u, 2'h0}, 8'h10, 2'(i + 1), nack);
      chkBit("wrong nack", nack, 1'b1);
      chkBit("wrong unmute", unmute, u);
      wrCtl({5'h0, ~u, 2'h0}, 8'h10, 2'(i), nack);
      chkBit("right nack", nack, 1'b0);
      u = ~u;
      chkBit("right unmute", unmute, u);
    end
  endtask : tAddress
  // Count restart pulses and cut a hang short.
  always @(posedge clk) begin
    cycles++;
    if (diagRestart === 1'b1) begin
      restarts++;
    end
    if (cycles == 60000) begin
      fails++;
      conclude();
    end
  end
  // Main sequence.
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    addrStrap = 2'h2;
    busEnablePin = 1'b1;
    standbyPin = 1'b1;
    stIn = 8'h00;
    chTwo = 8'h00;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    tReset();
    tFields();
    tStandby();
    tStatus();
    tAddress();
    conclude();
  end
endmodule : amp_i2c_control_diag_tb_top
